// ===== src/otp_pkg.sv
// package for the oscillator trim protect block: offsets, fields, resets, state types
// assumes a 32-bit apb with word-aligned registers, byte address four times the index
package otp_pkg;

  // ==========================================================
  // register indices and byte addresses
  localparam logic [15:0] IDX_CLK_PIN_CTRL  = 16'hf734;
  localparam logic [15:0] IDX_TRIM_PROTECT  = 16'hf736;
  localparam logic [15:0] IDX_TRIM_VALUE    = 16'hf737;
  localparam int          ADDR_W            = 18;
  localparam logic [17:0] ADDR_CLK_PIN_CTRL = {IDX_CLK_PIN_CTRL, 2'b00};
  localparam logic [17:0] ADDR_TRIM_PROTECT = {IDX_TRIM_PROTECT, 2'b00};
  localparam logic [17:0] ADDR_TRIM_VALUE   = {IDX_TRIM_VALUE, 2'b00};

  // ==========================================================
  // field positions
  localparam int POS_WRITE_VALID  = 7;
  localparam int POS_PROTECT_WE   = 6;
  localparam int POS_TRIM_LOCK    = 5;
  localparam int POS_DATA_WE      = 4;
  localparam int POS_PORTC_SEL_HI = 7;
  localparam int POS_PORTC_SEL_LO = 6;
  localparam int POS_TRIM_SIGN    = 7;
  localparam int TRIM_LSB         = 2;

  // ==========================================================
  // reset values and the trim write mask
  localparam logic [7:0] RST_TRIM_VALUE = 8'h00;
  localparam logic [1:0] RST_PORTC_SEL  = 2'h0;
  localparam logic [7:0] TRIM_WMASK     = 8'hfc;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    LD_RESET,
    LD_LOAD,
    LD_DONE
  } otp_load_state_t;

  typedef struct packed {
    logic protectWe;
    logic trimLock;
    logic dataWe;
  } otp_protect_t;

  typedef struct packed {
    otp_protect_t protect;
    logic [1:0]   portcSel;
    logic [7:0]   trimValue;
    logic [31:0]  prdata;
  } otp_state_t;

  typedef struct packed {
    otp_load_state_t state;
    logic            strobe;
    logic [7:0]      value;
  } otp_loader_t;

endpackage

// ===== src/otp_trim_loader.sv
// factory trim loader: presents the nonvolatile trim once after each reset
// assumes factoryTrim is stable from reset release onward
`timescale 1ns/1ns

module otp_trim_loader
  import otp_pkg::*;
#(
  parameter bit HAS_FLASH = 1'b1
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // nonvolatile side
  input  wire logic [7:0] factoryTrim,
  // load toward the trim register
  output logic            loadStrobe,
  output logic [7:0]      loadValue
);

  otp_loader_t cur;
  otp_loader_t next_cur;

  // ==========================================================
  // next state
  always_comb begin
    next_cur        = cur;
    next_cur.strobe = 1'b0;
    unique case (cur.state)
      LD_RESET: begin
        // value caught after release, never by the reset itself
        next_cur.value = factoryTrim & TRIM_WMASK;
        next_cur.state = LD_LOAD;
      end
      LD_LOAD: begin
        next_cur.strobe = HAS_FLASH; // R8
        next_cur.state  = LD_DONE;
      end
      LD_DONE: begin
        next_cur.state = LD_DONE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cur <= '{state: LD_RESET, strobe: 1'b0, value: RST_TRIM_VALUE};
    end else begin
      cur <= next_cur;
    end
  end

  assign loadStrobe = cur.strobe;
  assign loadValue  = cur.value;

endmodule

// ===== src/otp_trim_regs.sv
// oscillator trim protect registers behind an apb slave
// assumes an apb master on clk_sys and a trim input on the rc oscillator
//
// Notes on behaviour
// R1: protect bits change only if write carries 0 in write-valid; it reads 1.
// R2: lock and data-write-enable alterable only while protect-write-enable is 1.
// R3: valid write sets or clears protect-write-enable from its written bit.
// R4: lock/data-write-enable change needs valid write with protect-write-enable already 1.
// R5: lock blocks trim writes and stays 1 until reset despite writes of 0.
// R6: trim writes accepted only with lock 0 and data-write-enable 1.
// R7: trim is signed, bit 7 sign, codes 80 to 7c rising in steps of 4.
// R8: flash parts load the factory trim into the trim register after reset.
// R9: oscillator trim input follows the trim register directly.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns

module otp_trim_regs
  import otp_pkg::*;
#(
  parameter bit HAS_FLASH = 1'b1
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // nonvolatile trim
  input  wire logic [7:0]        factoryTrim,
  // oscillator and pins
  output logic signed [7:0]      oscTrim,
  output logic [1:0]             portcFuncSel,
  output logic                   trimLocked
);

  otp_state_t cur;
  otp_state_t next_cur;
  logic       loadStrobe;
  logic [7:0] loadValue;

  // ==========================================================
  // decode helpers
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == ADDR_CLK_PIN_CTRL) || (a == ADDR_TRIM_PROTECT) || (a == ADDR_TRIM_VALUE);
  endfunction

  function automatic logic [7:0] readByte(input otp_state_t s, input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_CLK_PIN_CTRL) begin
      v[POS_PORTC_SEL_HI] = s.portcSel[1];
      v[POS_PORTC_SEL_LO] = s.portcSel[0];
    end else if (a == ADDR_TRIM_PROTECT) begin
      v[POS_WRITE_VALID] = 1'b1; // R1
      v[POS_PROTECT_WE]  = s.protect.protectWe;
      v[POS_TRIM_LOCK]   = s.protect.trimLock;
      v[POS_DATA_WE]     = s.protect.dataWe;
    end else if (a == ADDR_TRIM_VALUE) begin
      v = s.trimValue & TRIM_WMASK;
    end
    readByte = v;
  endfunction

  // ==========================================================
  // factory trim loader
  otp_trim_loader #(
    .HAS_FLASH (HAS_FLASH)
  ) uLoader (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .factoryTrim (factoryTrim),
    .loadStrobe  (loadStrobe),
    .loadValue   (loadValue)
  );

  // ==========================================================
  // bus handshake
  logic setupPhase;
  logic writeHit;
  logic [7:0] wByte;
  logic laneOk;

  // zero wait states; read data latched in the setup cycle
  assign pready     = 1'b1;
  assign setupPhase = psel && !penable;
  assign writeHit   = psel && penable && pwrite && isMapped(paddr);
  assign wByte      = pwdata[7:0];
  // a write without the low byte lane touches nothing
  assign laneOk     = pstrb[0];
  assign pslverr    = psel && penable && !isMapped(paddr);

  // ==========================================================
  // next state
  always_comb begin
    next_cur = cur;
    if (setupPhase) begin
      next_cur.prdata = {24'h000000, readByte(cur, paddr)};
    end
    if (writeHit && laneOk) begin
      if (paddr == ADDR_CLK_PIN_CTRL) begin
        next_cur.portcSel = {wByte[POS_PORTC_SEL_HI], wByte[POS_PORTC_SEL_LO]};
      end else if (paddr == ADDR_TRIM_PROTECT) begin
        if (!wByte[POS_WRITE_VALID]) begin // R1
          next_cur.protect.protectWe = wByte[POS_PROTECT_WE]; // R3
          // old enable, not the one in this write, gates the other bits
          if (cur.protect.protectWe) begin // R2 R4
            // sticky: only a set gets through
            next_cur.protect.trimLock = cur.protect.trimLock | wByte[POS_TRIM_LOCK]; // R5
            next_cur.protect.dataWe   = wByte[POS_DATA_WE];
          end
        end
      end else if (paddr == ADDR_TRIM_VALUE) begin
        if (!cur.protect.trimLock && cur.protect.dataWe) begin // R5 R6
          // bits 1:0 are read-only zero, so the step is 4
          next_cur.trimValue = wByte & TRIM_WMASK; // R7
        end
      end
    end
    // the factory load beats a same-cycle bus write; it only comes once after reset
    if (loadStrobe) begin
      next_cur.trimValue = loadValue; // R8
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cur.protect   <= '{protectWe: 1'b0, trimLock: 1'b0, dataWe: 1'b0};
      cur.portcSel  <= RST_PORTC_SEL;
      cur.trimValue <= RST_TRIM_VALUE;
      cur.prdata    <= 32'h00000000;
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================
  // outputs
  assign prdata       = cur.prdata;
  assign oscTrim      = $signed(cur.trimValue); // R7 R9
  assign portcFuncSel = cur.portcSel;
  assign trimLocked   = cur.protect.trimLock;

endmodule

// ===== bench/otp_trim_regs_properties.sv
// checker: port relations of the trim protect registers
// assumes bind into otp_trim_regs, one clk_sys domain
`timescale 1ns/1ns
module otp_trim_regs_properties
  import otp_pkg::*;
#(
  parameter bit HAS_FLASH = 1'b1
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  // trim side
  input wire logic [7:0]        factoryTrim,
  input wire logic signed [7:0] oscTrim,
  input wire logic              trimLocked
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // read setup cycle, data latched there
  sequence s_rd(a); psel && !penable && !pwrite && paddr == a; endsequence
  // ==========================================================
  // properties
  property p_lock_sticky; trimLocked |=> trimLocked; endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");
  property p_frozen; trimLocked |=> $stable(oscTrim); endproperty
  a_frozen: assert property (p_frozen) else $error("locked trim moved");
  property p_lsb; oscTrim[1:0] == 2'b00; endproperty
  a_lsb: assert property (p_lsb) else $error("trim low bits set");
  // reset clears at once, factory load seen four samples after release
  property p_src; !$stable(oscTrim) |-> $past(sys_rst) || $past(sys_rst, 4)
    || $past(psel && penable && pwrite && paddr == ADDR_TRIM_VALUE); endproperty
  a_src: assert property (p_src) else $error("trim moved without write");
  property p_rd_trim; s_rd(ADDR_TRIM_VALUE) |=> prdata[7:0] == $past(oscTrim); endproperty
  a_rd_trim: assert property (p_rd_trim) else $error("trim pin differs");
  property p_rd_prot;
    s_rd(ADDR_TRIM_PROTECT) |=> prdata[7] && prdata[5] == $past(trimLocked); endproperty
  a_rd_prot: assert property (p_rd_prot) else $error("protect read wrong");
  property p_lock_rise; $rose(trimLocked) |-> $past(psel && penable && pwrite
    && paddr == ADDR_TRIM_PROTECT && !pwdata[7] && pwdata[5]); endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock set w/o write");
  property p_factory; $fell(sys_rst) |-> ##3
    oscTrim == (HAS_FLASH ? (factoryTrim & TRIM_WMASK) : 8'h00); endproperty
  a_factory: assert property (p_factory) else $error("factory trim absent");
endmodule
bind otp_trim_regs otp_trim_regs_properties #(.HAS_FLASH(HAS_FLASH)) u_props (.*);

// ===== bench/otp_trim_regs_tb.sv
// testbench: model of the protect and trim registers, apb master
// assumes zero-wait apb slave, reads checked after every write
`timescale 1ns/1ns
module otp_trim_regs_tb;
  import otp_pkg::*;
  logic              clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, d;
  logic [3:0]        pstrb = '0;
  logic              pready, pslverr, trimLocked, er;
  logic [7:0]        factoryTrim = 8'ha7, trim;
  logic signed [7:0] oscTrim;
  logic [1:0]        portcFuncSel, pc;
  logic              pWe, lk, dWe;
  int                n_fail = 0, samples_checked = 0;
  localparam logic [17:0] A[4] = '{ADDR_CLK_PIN_CTRL, ADDR_TRIM_PROTECT, ADDR_TRIM_VALUE,
                                   18'h00010};
  always #50 clk_sys = ~clk_sys;
  otp_trim_regs u_otp_trim_regs (.*);
  // ==========================================================
  // bus and compare tasks
  task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] v,
                      input logic [3:0] s);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    d = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic chk;
    logic [7:0] e[4];
    e = '{{pc, 6'h0}, {1'b1, pWe, lk, dWe, 4'h0}, trim, 8'h00};
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, A[i], 8'h00, 4'h0);
      cmp(d, {24'h0, e[i]});
      cmp(er, i == 3);
    end
    cmp({24'h0, oscTrim}, {24'h0, trim});
    cmp(trimLocked, lk);
    cmp(portcFuncSel, pc);
  endtask
  // model gating uses protect enable as it stood before the write
  task automatic wr(input logic [17:0] a, input logic [7:0] v, input logic [3:0] s);
    xfer(1'b1, a, v, s);
    if (s[0] && a == A[1] && !v[7]) begin
      if (pWe) begin
        lk |= v[5];
        dWe = v[4];
      end
      pWe = v[6];
    end
    if (s[0] && a == A[2] && !lk && dWe) trim = v & 8'hfc;
    if (s[0] && a == A[0]) pc = v[7:6];
    chk();
  endtask
  task automatic rst;
    sys_rst <= 1;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 0;
    {pWe, lk, dWe, pc} = '0;
    trim = factoryTrim & 8'hfc;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog, about three times the expected run
  initial begin
    #1000000;
    n_fail++;
    end_of_test();
  end
  // ==========================================================
  // scenarios
  initial begin
    void'($urandom(32'h5ba3));
    rst();
    chk();
    wr(A[2], 8'h5c, 4'h1);
    wr(A[1], 8'hd0, 4'h1);
    wr(A[1], 8'h10, 4'h1);
    wr(A[1], 8'h40, 4'h0);
    wr(A[1], 8'h40, 4'h1);
    wr(A[1], 8'h50, 4'h1);
    for (int c = 0; c < 64; c++) wr(A[2], 8'h80 + 8'(c * 4), 4'h1);
    wr(A[1], 8'h10, 4'h1);
    wr(A[1], 8'h40, 4'h1);
    wr(A[1], 8'h70, 4'h1);
    wr(A[2], 8'h24, 4'h1);
    wr(A[1], 8'h50, 4'h1);
    wr(A[0], 8'hc0, 4'h1);
    repeat (2) begin
      factoryTrim <= 8'($urandom);
      rst();
      repeat (60) wr(A[$urandom % 4], 8'($urandom), 4'($urandom));
    end
    end_of_test();
  end
endmodule
